// ===== fsem_pkg.sv
// constants, types and register map of the fieldbus state error monitor
package fsem_pkg;

  // clock and timing
  localparam int unsigned MCLK_HZ = 100_000_000;
  localparam int unsigned LOCK_TIME_MS = 1000;
  localparam int unsigned LOCK_CYCLES = LOCK_TIME_MS * (MCLK_HZ / 1000);
  localparam int unsigned LED_TICK_MS = 200;
  localparam int unsigned LED_TICK_CYCLES = LED_TICK_MS * (MCLK_HZ / 1000);
  localparam int LOCK_W = 27;
  localparam int LED_W = 25;
  localparam int WD_W = 16;

  // register offsets (byte addresses)
  localparam logic [11:0] OFF_IRQ_STATUS = 12'h000;
  localparam logic [11:0] OFF_IRQ_MASK = 12'h004;
  localparam logic [11:0] OFF_AL_CODE = 12'h008;
  localparam logic [11:0] OFF_AL_STATE = 12'h00c;
  localparam logic [11:0] OFF_CONTROL = 12'h010;
  localparam logic [11:0] OFF_FIRST_ERR = 12'h014;
  localparam logic [11:0] OFF_SYNC_MODE = 12'h018;
  localparam logic [11:0] OFF_EVENT_REQ = 12'h220;
  localparam logic [11:0] OFF_WD_DIVIDER = 12'h400;
  localparam logic [11:0] OFF_WD_TIME = 12'h420;

  // field positions
  localparam int ALM_UNDEF = 0;
  localparam int ALM_BOOT = 1;
  localparam int ALM_LOCK = 2;
  localparam int ALM_WDOG = 3;
  localparam int ALM_N = 4;
  localparam int CTRL_CLEAR_BIT = 0;
  localparam int STATE_ALARM_LSB = 8;
  localparam int EVREQ_PDO_BIT = 10;

  // reset values
  localparam logic [15:0] WD_DIV_RST = 16'h0063;
  localparam logic [15:0] WD_TIME_RST = 16'h03e8;
  localparam logic [3:0] MASK_RST = 4'h0;

  // state request codes, also used as reported state codes
  localparam logic [3:0] REQ_INIT = 4'h1;
  localparam logic [3:0] REQ_PREOP = 4'h2;
  localparam logic [3:0] REQ_BOOT = 4'h3;
  localparam logic [3:0] REQ_SAFEOP = 4'h4;
  localparam logic [3:0] REQ_OP = 4'h8;

  // status codes and first-error numbers
  localparam logic [15:0] CODE_UNDEF = 16'h0012;
  localparam logic [15:0] CODE_BOOT = 16'h0013;
  localparam logic [15:0] CODE_LOCK = 16'h002d;
  localparam logic [15:0] CODE_WDOG = 16'h001b;
  localparam logic [2:0] NUM_UNDEF = 3'h1;
  localparam logic [2:0] NUM_BOOT = 3'h2;
  localparam logic [2:0] NUM_LOCK = 3'h3;
  localparam logic [2:0] NUM_WDOG = 3'h4;

  // indicator patterns, one bit per tick, lsb first
  localparam logic [7:0] PAT_BLINK = 8'h55;
  localparam logic [7:0] PAT_SINGLE = 8'h01;
  localparam logic [7:0] PAT_DOUBLE = 8'h05;

  typedef enum logic [1:0] {
    SYNC_FREERUN = 2'h0,
    SYNC_DC = 2'h1,
    SYNC_SM2 = 2'h2
  } fsem_sync_t;

  typedef enum logic [1:0] {
    LED_OFF = 2'h0,
    LED_BLINK = 2'h1,
    LED_SINGLE = 2'h2,
    LED_DOUBLE = 2'h3
  } fsem_led_t;

  typedef enum logic [4:0] {
    ST_INIT = 5'h01,
    ST_PREOP = 5'h02,
    ST_SYNC = 5'h04,
    ST_SAFEOP = 5'h08,
    ST_OP = 5'h10
  } fsem_state_t;

  typedef struct packed {
    logic valid;
    logic [3:0] code;
  } fsem_req_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [31:0] wdata;
  } fsem_bus_t;

endpackage : fsem_pkg

// ===== fsem_timeout.sv
// timeout counter: pulses once when limit ticks pass while running
`timescale 1ns/1ps
`default_nettype none
module fsem_timeout #(
  parameter int W = 16
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic run,
  input wire logic restart,
  input wire logic tick,
  input wire logic [W-1:0] limit,
  output logic fire
);

  logic [W-1:0] cnt_q;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      cnt_q <= '0;
    end
    else if (!run || restart)
    begin
      cnt_q <= '0;
    end
    else if (tick && cnt_q != limit)
    begin
      cnt_q <= cnt_q + W'(1);
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      fire <= 1'b0;
    end
    else
    begin
      fire <= run && !restart && tick && limit != '0 && cnt_q == limit - W'(1);
    end
  end

endmodule : fsem_timeout
`default_nettype wire

// ===== fsem_indicator.sv
// error indicator: blinking, single flash or double flash pattern
`timescale 1ns/1ps
`default_nettype none
module fsem_indicator #(
  parameter int unsigned TICK_CYCLES = fsem_pkg::LED_TICK_CYCLES
) (
  input wire logic mclk,
  input wire logic rst,
  input wire fsem_pkg::fsem_led_t mode,
  output logic led
);

  logic [fsem_pkg::LED_W-1:0] div_q;
  logic [2:0] phase_q;
  logic [7:0] pat;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      div_q <= '0;
      phase_q <= 3'h0;
    end
    else if (div_q == fsem_pkg::LED_W'(TICK_CYCLES - 1))
    begin
      div_q <= '0;
      phase_q <= phase_q + 3'h1;
    end
    else
    begin
      div_q <= div_q + fsem_pkg::LED_W'(1);
    end
  end

  always_comb
  begin
    case (mode)
      fsem_pkg::LED_BLINK: pat = fsem_pkg::PAT_BLINK;
      fsem_pkg::LED_SINGLE: pat = fsem_pkg::PAT_SINGLE;
      fsem_pkg::LED_DOUBLE: pat = fsem_pkg::PAT_DOUBLE;
      default: pat = 8'h00;
    endcase
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      led <= 1'b0;
    end
    else
    begin
      led <= pat[phase_q];
    end
  end

endmodule : fsem_indicator
`default_nettype wire

// ===== fsem_monitor.sv
// fieldbus state request checker, lock and watchdog alarms, registers
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module fsem_monitor #(
  parameter int unsigned LOCK_CYCLES = fsem_pkg::LOCK_CYCLES,
  parameter int unsigned LED_TICK_CYCLES = fsem_pkg::LED_TICK_CYCLES
) (
  input wire logic mclk,
  input wire logic rst,
  input wire fsem_pkg::fsem_bus_t bus,
  input wire fsem_pkg::fsem_req_t state_req,
  input wire logic pll_locked,
  input wire logic rx_pdo_event,
  output logic [31:0] rd_data,
  output logic irq,
  output logic err_led,
  output logic [15:0] al_status_code,
  output logic [3:0] al_state
);

  fsem_pkg::fsem_state_t state_q;
  fsem_pkg::fsem_sync_t sync_mode_q;
  fsem_pkg::fsem_led_t led_mode_q;
  logic [fsem_pkg::ALM_N-1:0] alarm_q;
  logic [fsem_pkg::ALM_N-1:0] irq_stat_q;
  logic [fsem_pkg::ALM_N-1:0] irq_mask_q;
  logic [2:0] first_q;
  logic [15:0] wd_div_q;
  logic [15:0] wd_time_q;
  logic [15:0] pre_q;
  logic evreq_q;
  logic [fsem_pkg::ALM_N-1:0] ev;
  logic req_defined;
  logic clear_cmd;
  logic lock_fire;
  logic wd_fire;
  logic wd_run;
  logic wd_tick;
  logic [3:0] state_code;

  // request decode
  always_comb
  begin
    case (state_req.code)
      fsem_pkg::REQ_INIT,
      fsem_pkg::REQ_PREOP,
      fsem_pkg::REQ_BOOT,
      fsem_pkg::REQ_SAFEOP,
      fsem_pkg::REQ_OP: req_defined = 1'b1;
      default: req_defined = 1'b0;
    endcase
  end

  assign clear_cmd = bus.wr && bus.addr == fsem_pkg::OFF_CONTROL
    && bus.wdata[fsem_pkg::CTRL_CLEAR_BIT];

  always_comb
  begin
    ev = '0;
    ev[fsem_pkg::ALM_UNDEF] = state_req.valid && !req_defined;
    ev[fsem_pkg::ALM_BOOT] = state_req.valid && state_req.code == fsem_pkg::REQ_BOOT
      && state_q == fsem_pkg::ST_INIT;
    ev[fsem_pkg::ALM_LOCK] = lock_fire;
    ev[fsem_pkg::ALM_WDOG] = wd_fire && state_q == fsem_pkg::ST_OP;
  end

  // lock timer runs from entry into the synchronising state
  fsem_timeout #(
    .W(fsem_pkg::LOCK_W)
  ) u_lock_timer (
    .mclk(mclk),
    .rst(rst),
    .run(state_q == fsem_pkg::ST_SYNC && !pll_locked),
    .restart(1'b0),
    .tick(1'b1),
    .limit(fsem_pkg::LOCK_W'(LOCK_CYCLES)),
    .fire(lock_fire)
  );

  // only the receive channel has a watchdog, and only in OP
  assign wd_run = state_q == fsem_pkg::ST_OP && wd_time_q != 16'h0000;
  assign wd_tick = pre_q == wd_div_q;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      pre_q <= 16'h0000;
    end
    else if (!wd_run || rx_pdo_event || wd_tick)
    begin
      pre_q <= 16'h0000;
    end
    else
    begin
      pre_q <= pre_q + 16'h0001;
    end
  end

  fsem_timeout #(
    .W(fsem_pkg::WD_W)
  ) u_wd_timer (
    .mclk(mclk),
    .rst(rst),
    .run(wd_run),
    .restart(rx_pdo_event),
    .tick(wd_tick),
    .limit(wd_time_q),
    .fire(wd_fire)
  );

  // slave state machine
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= fsem_pkg::ST_INIT;
    end
    else if (ev[fsem_pkg::ALM_WDOG])
    begin
      state_q <= fsem_pkg::ST_SAFEOP;
    end
    else if (ev[fsem_pkg::ALM_UNDEF])
    begin
      if (state_q == fsem_pkg::ST_OP)
      begin
        state_q <= fsem_pkg::ST_SAFEOP;
      end
    end
    else if (ev[fsem_pkg::ALM_LOCK])
    begin
      state_q <= fsem_pkg::ST_PREOP;
    end
    else if (state_req.valid && state_req.code != fsem_pkg::REQ_BOOT)
    begin
      case (state_req.code)
        fsem_pkg::REQ_INIT: state_q <= fsem_pkg::ST_INIT;
        fsem_pkg::REQ_PREOP: state_q <= fsem_pkg::ST_PREOP;
        fsem_pkg::REQ_SAFEOP:
          if (state_q == fsem_pkg::ST_PREOP)
          begin
            state_q <= (sync_mode_q == fsem_pkg::SYNC_FREERUN) ? fsem_pkg::ST_SAFEOP
              : fsem_pkg::ST_SYNC;
          end
          else if (state_q == fsem_pkg::ST_OP)
          begin
            state_q <= fsem_pkg::ST_SAFEOP;
          end
        fsem_pkg::REQ_OP:
          if (state_q == fsem_pkg::ST_SAFEOP)
          begin
            state_q <= fsem_pkg::ST_OP;
          end
        default: state_q <= state_q;
      endcase
    end
    else if (state_q == fsem_pkg::ST_SYNC && pll_locked)
    begin
      state_q <= fsem_pkg::ST_SAFEOP;
    end
  end

  // alarm latches, set wins over clear
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      alarm_q <= '0;
    end
    else
    begin
      alarm_q <= (clear_cmd ? '0 : alarm_q) | ev;
    end
  end

  // status code and indicator follow the latest error
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      al_status_code <= 16'h0000;
      led_mode_q <= fsem_pkg::LED_OFF;
    end
    else if (ev[fsem_pkg::ALM_WDOG])
    begin
      al_status_code <= fsem_pkg::CODE_WDOG;
      led_mode_q <= fsem_pkg::LED_DOUBLE;
    end
    else if (ev[fsem_pkg::ALM_LOCK])
    begin
      al_status_code <= fsem_pkg::CODE_LOCK;
      led_mode_q <= fsem_pkg::LED_SINGLE;
    end
    else if (ev[fsem_pkg::ALM_UNDEF])
    begin
      al_status_code <= fsem_pkg::CODE_UNDEF;
      led_mode_q <= fsem_pkg::LED_BLINK;
    end
    else if (ev[fsem_pkg::ALM_BOOT])
    begin
      al_status_code <= fsem_pkg::CODE_BOOT;
      led_mode_q <= fsem_pkg::LED_BLINK;
    end
    else if (clear_cmd)
    begin
      al_status_code <= 16'h0000;
      led_mode_q <= fsem_pkg::LED_OFF;
    end
  end

  // first error number held until cleared
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      first_q <= 3'h0;
    end
    else if (first_q == 3'h0 || clear_cmd)
    begin
      if (ev[fsem_pkg::ALM_WDOG])
        first_q <= fsem_pkg::NUM_WDOG;
      else if (ev[fsem_pkg::ALM_LOCK])
        first_q <= fsem_pkg::NUM_LOCK;
      else if (ev[fsem_pkg::ALM_UNDEF])
        first_q <= fsem_pkg::NUM_UNDEF;
      else if (ev[fsem_pkg::ALM_BOOT])
        first_q <= fsem_pkg::NUM_BOOT;
      else
        first_q <= 3'h0;
    end
  end

  fsem_indicator #(
    .TICK_CYCLES(LED_TICK_CYCLES)
  ) u_indicator (
    .mclk(mclk),
    .rst(rst),
    .mode(led_mode_q),
    .led(err_led)
  );

  // software registers
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      irq_mask_q <= fsem_pkg::MASK_RST;
      sync_mode_q <= fsem_pkg::SYNC_FREERUN;
      wd_div_q <= fsem_pkg::WD_DIV_RST;
      wd_time_q <= fsem_pkg::WD_TIME_RST;
    end
    else if (bus.wr)
    begin
      case (bus.addr)
        fsem_pkg::OFF_IRQ_MASK: irq_mask_q <= bus.wdata[fsem_pkg::ALM_N-1:0];
        fsem_pkg::OFF_SYNC_MODE: sync_mode_q <= fsem_pkg::fsem_sync_t'(bus.wdata[1:0]);
        fsem_pkg::OFF_WD_DIVIDER: wd_div_q <= bus.wdata[15:0];
        fsem_pkg::OFF_WD_TIME: wd_time_q <= bus.wdata[15:0];
        default: wd_div_q <= wd_div_q;
      endcase
    end
  end

  // interrupt status, write one to clear, set wins
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      irq_stat_q <= '0;
    end
    else if (bus.wr && bus.addr == fsem_pkg::OFF_IRQ_STATUS)
    begin
      irq_stat_q <= (irq_stat_q & ~bus.wdata[fsem_pkg::ALM_N-1:0]) | ev;
    end
    else
    begin
      irq_stat_q <= irq_stat_q | ev;
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= |(irq_stat_q & irq_mask_q);
    end
  end

  // receive event flag, cleared by reading it, set wins
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      evreq_q <= 1'b0;
    end
    else
    begin
      evreq_q <= (evreq_q && !(bus.rd && bus.addr == fsem_pkg::OFF_EVENT_REQ)) || rx_pdo_event;
    end
  end

  always_comb
  begin
    case (state_q)
      fsem_pkg::ST_INIT: state_code = fsem_pkg::REQ_INIT;
      fsem_pkg::ST_PREOP,
      fsem_pkg::ST_SYNC: state_code = fsem_pkg::REQ_PREOP;
      fsem_pkg::ST_SAFEOP: state_code = fsem_pkg::REQ_SAFEOP;
      fsem_pkg::ST_OP: state_code = fsem_pkg::REQ_OP;
      default: state_code = fsem_pkg::REQ_INIT;
    endcase
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      al_state <= fsem_pkg::REQ_INIT;
    end
    else
    begin
      al_state <= state_code;
    end
  end

  // read data, one cycle after the strobe, zero otherwise
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      rd_data <= 32'h0000_0000;
    end
    else if (!bus.rd)
    begin
      rd_data <= 32'h0000_0000;
    end
    else
    begin
      case (bus.addr)
        fsem_pkg::OFF_IRQ_STATUS: rd_data <= {28'h0000000, irq_stat_q};
        fsem_pkg::OFF_IRQ_MASK: rd_data <= {28'h0000000, irq_mask_q};
        fsem_pkg::OFF_AL_CODE: rd_data <= {16'h0000, al_status_code};
        fsem_pkg::OFF_AL_STATE: rd_data <= {20'h00000, alarm_q, 4'h0, state_code};
        fsem_pkg::OFF_FIRST_ERR: rd_data <= {29'h00000000, first_q};
        fsem_pkg::OFF_SYNC_MODE: rd_data <= {30'h00000000, sync_mode_q};
        fsem_pkg::OFF_EVENT_REQ: rd_data <= 32'(evreq_q) << fsem_pkg::EVREQ_PDO_BIT;
        fsem_pkg::OFF_WD_DIVIDER: rd_data <= {16'h0000, wd_div_q};
        fsem_pkg::OFF_WD_TIME: rd_data <= {16'h0000, wd_time_q};
        default: rd_data <= 32'h0000_0000;
      endcase
    end
  end

  // helper: cycles spent in the synchronising state
  logic [fsem_pkg::LOCK_W-1:0] sync_age_q;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      sync_age_q <= '0;
    else if (state_q != fsem_pkg::ST_SYNC || pll_locked)
      sync_age_q <= '0;
    else
      sync_age_q <= sync_age_q + fsem_pkg::LOCK_W'(1);
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_undef_alarm_set: assert property (ev[fsem_pkg::ALM_UNDEF] |=> alarm_q[fsem_pkg::ALM_UNDEF]
    && al_status_code == 16'h0012) else $error("undefined request not latched");
  a_undef_op_fallback: assert property (ev[fsem_pkg::ALM_UNDEF] && state_q == fsem_pkg::ST_OP
    |=> state_q == fsem_pkg::ST_SAFEOP) else $error("op did not fall back");
  a_undef_keeps_state: assert property (ev[fsem_pkg::ALM_UNDEF] && !wd_fire
    && state_q != fsem_pkg::ST_OP |=> $stable(state_q)) else $error("state moved");
  a_boot_stays_init: assert property (ev[fsem_pkg::ALM_BOOT] |=> state_q == fsem_pkg::ST_INIT
    && al_status_code == 16'h0013 && led_mode_q == fsem_pkg::LED_BLINK)
    else $error("bootstrap alarm wrong");
  a_lock_after_time: assert property (lock_fire |-> 32'(sync_age_q) == LOCK_CYCLES)
    else $error("lock alarm at wrong time");
  a_lock_to_preop: assert property (lock_fire |=> state_q == fsem_pkg::ST_PREOP
    && al_status_code == 16'h002d && led_mode_q == fsem_pkg::LED_SINGLE)
    else $error("lock alarm wrong");
  a_wdog_only_op: assert property (wd_fire |-> $past(state_q) == fsem_pkg::ST_OP)
    else $error("watchdog outside op");
  a_wdog_fallback: assert property (ev[fsem_pkg::ALM_WDOG] |=> state_q == fsem_pkg::ST_SAFEOP
    && al_status_code == 16'h001b && led_mode_q == fsem_pkg::LED_DOUBLE)
    else $error("watchdog alarm wrong");
  a_first_err_held: assert property (first_q != 3'h0 && !clear_cmd |=> $stable(first_q))
    else $error("first error changed");
  a_clear_all: assert property (clear_cmd && ev == '0 |=> alarm_q == '0 && first_q == 3'h0)
    else $error("clear did not clear");
  a_irq_masked: assert property ((irq_stat_q & irq_mask_q) != '0 |=> irq)
    else $error("interrupt missing");

  c_undef_in_op: cover property (ev[fsem_pkg::ALM_UNDEF] && state_q == fsem_pkg::ST_OP);
  c_lock_timeout: cover property (lock_fire);
  c_wdog_expiry: cover property (wd_fire);
  c_clear_after_alarm: cover property (alarm_q != '0 ##1 clear_cmd);

endmodule : fsem_monitor
`default_nettype wire

// ===== fsem_host_model.sv
// host master model: state requests and periodic receive process data frames
`timescale 1ns/1ps
`default_nettype none
module fsem_host_model (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] pdo_period,
  output var fsem_pkg::fsem_req_t state_req,
  output logic rx_pdo_event
);
  logic [7:0] gap_q;
  initial state_req = '0;
  // one frame every pdo_period cycles at a constant interval, none while it is 0
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      gap_q <= 8'h00;
      rx_pdo_event <= 1'b0;
    end
    else if (pdo_period == 8'h00 || gap_q + 8'h01 < pdo_period)
    begin
      gap_q <= (pdo_period == 8'h00) ? 8'h00 : gap_q + 8'h01;
      rx_pdo_event <= 1'b0;
    end
    else
    begin
      gap_q <= 8'h00;
      rx_pdo_event <= 1'b1;
    end
  end
  // one-cycle request; the code field is inverted once released
  task automatic send_req(input logic [3:0] code);
    @(posedge mclk);
    state_req <= '{valid: 1'b1, code: code};
    @(posedge mclk);
    state_req <= '{valid: 1'b0, code: ~code};
  endtask : send_req
endmodule : fsem_host_model
`default_nettype wire

// ===== fsem_monitor_test.sv
// self-checking testbench of the fieldbus state error monitor
`timescale 1ns/1ps
`default_nettype none
module fsem_monitor_test;
  localparam int unsigned LOCK_N = 50;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  fsem_pkg::fsem_bus_t bus = '0;
  logic pll_locked = 1'b0;
  logic [7:0] pdo_period = 8'h00;
  fsem_pkg::fsem_req_t state_req;
  logic rx_pdo_event;
  logic [31:0] rd_data;
  logic irq;
  logic err_led;
  logic [15:0] al_status_code;
  logic [3:0] al_state;
  int num_errors = 0;
  int num_checks = 0;
  logic [3:0] bad_codes [6] = '{4'h0, 4'h5, 4'h6, 4'h7, 4'h9, 4'hf};

  always #5 mclk = ~mclk;

  fsem_host_model host (.mclk(mclk), .rst(rst), .pdo_period(pdo_period),
    .state_req(state_req), .rx_pdo_event(rx_pdo_event));

  fsem_monitor #(.LOCK_CYCLES(LOCK_N), .LED_TICK_CYCLES(4)) dut (.mclk(mclk), .rst(rst),
    .bus(bus), .state_req(state_req), .pll_locked(pll_locked), .rx_pdo_event(rx_pdo_event),
    .rd_data(rd_data), .irq(irq), .err_led(err_led), .al_status_code(al_status_code),
    .al_state(al_state));

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    num_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge mclk);
    bus.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    @(posedge mclk);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge mclk);
    bus.rd <= 1'b0;
    #1;
    chk(rd_data, exp, "read data");
  endtask : rd

  task automatic req(input logic [3:0] c);
    host.send_req(c);
    repeat (3) @(posedge mclk);
    #1;
  endtask : req

  task automatic see(input logic [3:0] st, input logic [15:0] code);
    chk({28'h0, al_state}, {28'h0, st}, "state");
    chk({16'h0, al_status_code}, {16'h0, code}, "status code");
  endtask : see

  // lit cycles over one 32-cycle indicator frame
  task automatic leds(input int exp);
    int n;
    n = 0;
    repeat (8) @(posedge mclk);
    repeat (32)
    begin
      @(posedge mclk);
      #1;
      if (err_led === 1'b1)
        n++;
    end
    chk(n, exp, "indicator lit cycles");
  endtask : leds

  task automatic wait_code(input logic [15:0] c);
    int n;
    n = 0;
    while (al_status_code !== c && n < 30)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (al_status_code !== c)
    begin
      num_errors++;
      $display("BAD %0t status code %h never seen", $time, c);
      complete_run();
    end
    // reported state lags the status code by one cycle
    @(posedge mclk);
    #1;
  endtask : wait_code

  task automatic clear_all();
    wr(fsem_pkg::OFF_CONTROL, 32'h1);
    repeat (2) @(posedge mclk);
    #1;
  endtask : clear_all

  task automatic t_reset();
    see(fsem_pkg::REQ_INIT, 16'h0000);
    chk({irq, err_led}, 2'b00, "irq and led");
    rd(fsem_pkg::OFF_IRQ_MASK, 32'h0);
    rd(fsem_pkg::OFF_WD_DIVIDER, 32'h0063);
    rd(fsem_pkg::OFF_WD_TIME, 32'h03e8);
    rd(fsem_pkg::OFF_SYNC_MODE, 32'h0);
    rd(12'h100, 32'h0);
    wr(fsem_pkg::OFF_WD_TIME, 32'h1234);
    rd(fsem_pkg::OFF_WD_TIME, 32'h1234);
    wr(fsem_pkg::OFF_AL_CODE, 32'h5555);
    rd(fsem_pkg::OFF_AL_CODE, 32'h0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_undef();
    wr(fsem_pkg::OFF_IRQ_MASK, 32'hf);
    foreach (bad_codes[i])
    begin
      req(bad_codes[i]);
      see(fsem_pkg::REQ_INIT, fsem_pkg::CODE_UNDEF);
    end
    chk(irq, 1'b1, "irq");
    rd(fsem_pkg::OFF_IRQ_STATUS, 32'h1);
    rd(fsem_pkg::OFF_FIRST_ERR, 32'h1);
    leds(16);
    wr(fsem_pkg::OFF_IRQ_STATUS, 32'h1);
    repeat (2) @(posedge mclk);
    #1;
    chk(irq, 1'b0, "irq after status clear");
    chk(al_status_code, fsem_pkg::CODE_UNDEF, "code latched");
    clear_all();
    see(fsem_pkg::REQ_INIT, 16'h0000);
    rd(fsem_pkg::OFF_FIRST_ERR, 32'h0);
    leds(0);
    req(fsem_pkg::REQ_PREOP);
    see(fsem_pkg::REQ_PREOP, 16'h0000);
    req(4'ha);
    see(fsem_pkg::REQ_PREOP, fsem_pkg::CODE_UNDEF);
    req(fsem_pkg::REQ_SAFEOP);
    req(4'hb);
    see(fsem_pkg::REQ_SAFEOP, fsem_pkg::CODE_UNDEF);
    req(fsem_pkg::REQ_OP);
    req(4'h5);
    see(fsem_pkg::REQ_SAFEOP, fsem_pkg::CODE_UNDEF);
    clear_all();
    $display("test undefined request done");
  endtask : t_undef

  task automatic t_boot();
    req(fsem_pkg::REQ_INIT);
    req(fsem_pkg::REQ_BOOT);
    see(fsem_pkg::REQ_INIT, fsem_pkg::CODE_BOOT);
    rd(fsem_pkg::OFF_FIRST_ERR, 32'h2);
    leds(16);
    clear_all();
    req(fsem_pkg::REQ_PREOP);
    req(fsem_pkg::REQ_BOOT);
    see(fsem_pkg::REQ_PREOP, 16'h0000);
    $display("test bootstrap done");
  endtask : t_boot

  task automatic t_lock();
    wr(fsem_pkg::OFF_SYNC_MODE, 32'h1);
    req(fsem_pkg::REQ_SAFEOP);
    repeat (LOCK_N - 6) @(posedge mclk);
    #1;
    see(fsem_pkg::REQ_PREOP, 16'h0000);
    wait_code(fsem_pkg::CODE_LOCK);
    see(fsem_pkg::REQ_PREOP, fsem_pkg::CODE_LOCK);
    leds(4);
    clear_all();
    wr(fsem_pkg::OFF_SYNC_MODE, 32'h2);
    pll_locked <= 1'b1;
    req(fsem_pkg::REQ_SAFEOP);
    repeat (LOCK_N + 10) @(posedge mclk);
    #1;
    see(fsem_pkg::REQ_SAFEOP, 16'h0000);
    $display("test lock done");
  endtask : t_lock

  task automatic t_wdog();
    wr(fsem_pkg::OFF_WD_DIVIDER, 32'h0);
    wr(fsem_pkg::OFF_WD_TIME, 32'ha);
    repeat (40) @(posedge mclk);
    #1;
    see(fsem_pkg::REQ_SAFEOP, 16'h0000);
    pdo_period <= 8'h04;
    req(fsem_pkg::REQ_OP);
    repeat (60) @(posedge mclk);
    #1;
    see(fsem_pkg::REQ_OP, 16'h0000);
    rd(fsem_pkg::OFF_EVENT_REQ, 32'h400);
    req(4'h6);
    req(fsem_pkg::REQ_OP);
    pdo_period <= 8'h00;
    wait_code(fsem_pkg::CODE_WDOG);
    see(fsem_pkg::REQ_SAFEOP, fsem_pkg::CODE_WDOG);
    rd(fsem_pkg::OFF_FIRST_ERR, 32'h1);
    rd(fsem_pkg::OFF_AL_STATE, 32'h904);
    leds(8);
    rd(fsem_pkg::OFF_IRQ_STATUS, 32'hf);
    wr(fsem_pkg::OFF_IRQ_MASK, 32'h0);
    repeat (2) @(posedge mclk);
    #1;
    chk(irq, 1'b0, "irq masked");
    clear_all();
    rd(fsem_pkg::OFF_AL_STATE, 32'h004);
    $display("test watchdog done");
  endtask : t_wdog

  initial
  begin
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1;
    t_reset();
    t_undef();
    t_boot();
    t_lock();
    t_wdog();
    complete_run();
  end
endmodule : fsem_monitor_test
`default_nettype wire
